// [logic/iwd_consts.svh]
// constants for the internal i/o window decoder
`ifndef IWD_CONSTS_SVH
`define IWD_CONSTS_SVH
`define IWD_WINDOW_SIZE     64
`define IWD_CTRL_OFFSET     6'h3f
`define IWD_BASE_HI_POS     7
`define IWD_BASE_LO_POS     6
`define IWD_HALT_POS        5
`define IWD_CTRL_RESET      3'h0
`define IWD_MIRROR_CYCLES   3
`endif

// [logic/iwd_pkg.sv]
// types for the internal i/o window decoder
package iwd_pkg;
	typedef enum logic [1:0]
	{
		IWD_IDLE  = 2'b00,
		IWD_T1    = 2'b01,
		IWD_T2    = 2'b11,
		IWD_T3    = 2'b10
	} iwd_state_e;
	typedef logic [7:0] iwd_byte_t;
endpackage

// [logic/iwd_reg_mem.sv]
// register storage for the internal window, registered read
`timescale 1ns/1ps
module iwd_reg_mem
#(
	parameter int DEPTH = 64
)
(
	// clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      rst,
	// write port
	input  wire logic                      wrEn,
	input  wire logic [$clog2(DEPTH)-1:0]  wrAddr,
	input  wire logic [7:0]                wrData,
	// read port
	input  wire logic [$clog2(DEPTH)-1:0]  rdAddr,
	output logic      [7:0]                rdData
);
	logic [7:0] mem [DEPTH];

	if (DEPTH < 2)
	begin : g_depth_check
		$error("depth too small");
	end

	always_ff @(posedge ref_clk)
	begin
		if (wrEn)
			mem[wrAddr] <= wrData;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			rdData <= 8'h00;
		else
			rdData <= mem[rdAddr];
	end
endmodule

// [logic/iwd_mirror.sv]
// fixed-length external mirror cycle sequencer
`timescale 1ns/1ps
`include "iwd_consts.svh"
module iwd_mirror
(
	// clock and reset
	input  wire logic  ref_clk,
	input  wire logic  rst,
	// start request
	input  wire logic  start,
	input  wire logic  isWrite,
	// external strobes
	output logic       extIorq,
	output logic       extRd,
	output logic       extWr,
	output logic       busy,
	output logic       done
);
	import iwd_pkg::*;
	iwd_state_e state;
	logic       wrCyc;

	// fixed three states, no wait sampling
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			state <= IWD_IDLE;
		else
			case (state)
				IWD_IDLE: if (start) state <= IWD_T1;
				IWD_T1:   state <= IWD_T2;
				IWD_T2:   state <= IWD_T3;
				IWD_T3:   state <= IWD_IDLE;
				default:  state <= IWD_IDLE;
			endcase
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			wrCyc <= 1'b0;
		else if (start && state == IWD_IDLE)
			wrCyc <= isWrite;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			extIorq <= 1'b0;
			extRd   <= 1'b0;
			extWr   <= 1'b0;
			done    <= 1'b0;
		end
		else
		begin
			extIorq <= (state == IWD_T1) || (state == IWD_T2);
			extRd   <= !wrCyc && ((state == IWD_T1) || (state == IWD_T2));
			extWr   <= wrCyc && (state == IWD_T2);
			done    <= state == IWD_T3;
		end
	end

	assign busy = state != IWD_IDLE;

	fixed_len_a: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(busy) |-> busy [*3] ##1 !busy)
		else $error("mirror length wrong");
endmodule

// [logic/iwd_top.sv]
// internal i/o window decode, relocation and access mirroring
`timescale 1ns/1ps
`include "iwd_consts.svh"
module iwd_top
(
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// cpu i/o access
	input  wire logic             ioReq,
	input  wire logic             ioWrite,
	input  wire logic [15:0]      ioAddr,
	input  wire iwd_pkg::iwd_byte_t ioWrData,
	output logic                  ioAck,
	output logic                  ioInternal,
	output iwd_pkg::iwd_byte_t    ioRdData,
	// external bus
	input  wire logic             extWait,
	input  wire iwd_pkg::iwd_byte_t extRdData,
	output logic                  extIorq,
	output logic                  extRd,
	output logic                  extWr,
	output logic [15:0]           extAddr,
	output iwd_pkg::iwd_byte_t    extWrData,
	// control state
	output logic [1:0]            window_base_field,
	output logic                  peripheral_halt_mode
);
	import iwd_pkg::*;

	logic       window_base_bit_hi;
	logic       window_base_bit_lo;
	logic       peripheral_halt_enable;
	logic       hit;
	logic       ctrlHit;
	logic       accept;
	logic       busy;
	logic       done;
	logic       pendInt;
	logic       extWaitS1;
	logic       extWaitS2;
	logic       extBusy;
	logic       extDone;
	logic [1:0] extCnt;
	logic [5:0] offs;
	logic [7:0] memRd;
	logic [7:0] ctrlRd;

	assign offs    = ioAddr[5:0];
	assign hit     = (ioAddr[15:8] == 8'h00)
		&& (ioAddr[7:6] == {window_base_bit_hi, window_base_bit_lo});
	assign ctrlHit = hit && (offs == `IWD_CTRL_OFFSET);
	// the answer cycles block a second take while the cpu still holds its request
	assign accept  = ioReq && !busy && !extBusy && !done && !ioAck;
	assign ioInternal = hit;
	assign window_base_field = {window_base_bit_hi, window_base_bit_lo};
	assign peripheral_halt_mode = peripheral_halt_enable;

	// control register
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			{window_base_bit_hi, window_base_bit_lo, peripheral_halt_enable} <= `IWD_CTRL_RESET;
		end
		else if (accept && ioWrite && ctrlHit)
		begin
			window_base_bit_hi     <= ioWrData[`IWD_BASE_HI_POS];
			window_base_bit_lo     <= ioWrData[`IWD_BASE_LO_POS];
			peripheral_halt_enable <= ioWrData[`IWD_HALT_POS];
		end
	end

	assign ctrlRd = {window_base_bit_hi, window_base_bit_lo, peripheral_halt_enable, 5'h00};

	// other 63 slots of the window
	iwd_reg_mem #(.DEPTH(`IWD_WINDOW_SIZE)) uMem
	(
		.ref_clk (ref_clk),
		.rst     (rst),
		.wrEn    (accept && ioWrite && hit && !ctrlHit),
		.wrAddr  (offs),
		.wrData  (ioWrData),
		.rdAddr  (extAddr[5:0]),
		.rdData  (memRd)
	);

	// mirror sequencer for internal hits
	logic mIorq;
	logic mRd;
	logic mWr;
	iwd_mirror uMirror
	(
		.ref_clk (ref_clk),
		.rst     (rst),
		.start   (accept && hit),
		.isWrite (ioWrite),
		.extIorq (mIorq),
		.extRd   (mRd),
		.extWr   (mWr),
		.busy    (busy),
		.done    (done)
	);

	// wait input synchroniser, used only by true external cycles
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			extWaitS1 <= 1'b0;
			extWaitS2 <= 1'b0;
		end
		else
		begin
			extWaitS1 <= extWait;
			extWaitS2 <= extWaitS1;
		end
	end

	// plain external cycle: stretched while wait is asserted
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			extCnt <= 2'h0;
		else if (accept && !hit)
			extCnt <= 2'h3;
		else if (extCnt != 2'h0 && !(extCnt == 2'h1 && extWaitS2))
			extCnt <= extCnt - 2'h1;
	end
	assign extBusy = extCnt != 2'h0;
	assign extDone = extCnt == 2'h1 && !extWaitS2;

	logic pWrite;
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			extAddr   <= 16'h0000;
			extWrData <= 8'h00;
			pWrite    <= 1'b0;
			pendInt   <= 1'b0;
		end
		else if (accept)
		begin
			extAddr   <= ioAddr;
			extWrData <= ioWrData;
			pWrite    <= ioWrite;
			pendInt   <= hit && ctrlHit;
		end
	end

	assign extIorq = mIorq || extBusy;
	assign extRd   = mRd || (extBusy && !pWrite);
	assign extWr   = mWr || (extBusy && pWrite && extCnt == 2'h2);

	// answer strobe: one cycle per finished access
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			ioAck <= 1'b0;
		else
			ioAck <= done || extDone;
	end

	// answer data: internal data wins over external data
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			ioRdData <= 8'h00;
		else if (done)
			ioRdData <= pendInt ? ctrlRd : memRd;
		else if (extDone)
			ioRdData <= extRdData;
	end

	// decode checks
	base_reset_a: assert property (@(posedge ref_clk)
		$fell(rst)
		|-> window_base_field == 2'b00)
		else $error("base not zero after reset");

	upper_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
		ioAddr[15:8] != 8'h00
		|-> !ioInternal)
		else $error("internal hit outside low page");

	base_match_a: assert property (@(posedge ref_clk) disable iff (rst)
		ioInternal
		|-> ioAddr[7:6] == window_base_field)
		else $error("hit off base");

	window_span_a: assert property (@(posedge ref_clk) disable iff (rst)
		ioReq && ioAddr[15:6] == {8'h00, window_base_field}
		|-> ioInternal)
		else $error("window slot missed");

	mirror_addr_a: assert property (@(posedge ref_clk) disable iff (rst)
		mIorq
		|-> extAddr[15:8] == 8'h00)
		else $error("mirror outside low page");

	// control register checks
	ctrl_write_a: assert property (@(posedge ref_clk) disable iff (rst)
		accept && ioWrite && ctrlHit
		|=> window_base_field == $past(ioWrData[`IWD_BASE_HI_POS:`IWD_BASE_LO_POS]))
		else $error("base not loaded");

	halt_write_a: assert property (@(posedge ref_clk) disable iff (rst)
		accept && ioWrite && ctrlHit
		|=> peripheral_halt_mode == $past(ioWrData[`IWD_HALT_POS]))
		else $error("halt bit not loaded");

	base_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		!(accept && ioWrite && ctrlHit)
		|=> $stable(window_base_field))
		else $error("base moved without write");

	halt_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		!(accept && ioWrite && ctrlHit)
		|=> $stable(peripheral_halt_mode))
		else $error("halt moved without write");

	ctrl_read_a: assert property (@(posedge ref_clk) disable iff (rst)
		accept && !ioWrite && ctrlHit
		|-> ##5 ioRdData[7:5] == $past(ctrlRd[7:5], 5))
		else $error("control read wrong");

	ctrl_low_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
		done && pendInt
		|=> ioRdData[4:0] == 5'h00)
		else $error("control low bits not zero");

	// mirror checks
	write_mirror_a: assert property (@(posedge ref_clk) disable iff (rst)
		accept && ioWrite && hit
		|-> ##3 extWr)
		else $error("no mirrored write");

	write_once_a: assert property (@(posedge ref_clk) disable iff (rst)
		busy && extWr
		|=> !extWr)
		else $error("mirrored write too long");

	read_mirror_a: assert property (@(posedge ref_clk) disable iff (rst)
		accept && !ioWrite && hit
		|-> ##2 extRd ##1 extRd)
		else $error("no mirrored read");

	read_ignored_a: assert property (@(posedge ref_clk) disable iff (rst)
		done && !pendInt && memRd != extRdData
		|=> ioRdData != $past(extRdData))
		else $error("external data used on internal read");

	no_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
		accept && hit
		|-> ##5 ioAck)
		else $error("mirror stretched");

	no_overlap_a: assert property (@(posedge ref_clk) disable iff (rst)
		busy
		|-> !extBusy)
		else $error("plain cycle during mirror");

	// answer checks
	ack_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
		ioAck
		|=> !ioAck)
		else $error("acknowledge longer than one cycle");

	one_taken_a: assert property (@(posedge ref_clk) disable iff (rst)
		busy || extBusy || done || ioAck
		|-> !accept)
		else $error("request taken while answering");

	cov_reloc_c: cover property (@(posedge ref_clk)
		accept && ioWrite && ctrlHit && ioWrData[7:6] != 2'b00);
	cov_int_rd_c: cover property (@(posedge ref_clk)
		accept && !ioWrite && hit);
	cov_ext_wait_c: cover property (@(posedge ref_clk)
		extBusy && extWaitS2);
	cov_halt_c: cover property (@(posedge ref_clk)
		$rose(peripheral_halt_mode));
	cov_ext_wr_c: cover property (@(posedge ref_clk)
		accept && ioWrite && !hit);
endmodule

// [tb/iwd_ext_dev.sv]
// external i/o device model on the far side of the bus
`timescale 1ns/1ps
module iwd_ext_dev
	import iwd_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// bus from the device
	input  wire logic        extIorq,
	input  wire logic        extRd,
	input  wire logic [15:0] extAddr,
	// bench control
	input  wire logic        stall,
	// answers to the device
	output logic             extWait,
	output iwd_byte_t        extRdData
);
	logic      [2:0] waitCnt;
	iwd_byte_t       lastData;

	// wait only for the first three cycles of a bus cycle
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			waitCnt <= 3'h0;
		else if (!extIorq)
			waitCnt <= 3'h0;
		else if (waitCnt != 3'h7)
			waitCnt <= waitCnt + 3'h1;
	end
	assign extWait = stall && extIorq && (waitCnt < 3'h3);

	// released data line shows the inverse of the last value
	always_ff @(posedge ref_clk)
	begin
		if (extRd)
			lastData <= extRdData;
	end
	assign extRdData = extRd ? (extAddr[7:0] ^ 8'h5a) : ~lastData;
endmodule

// [tb/internal_io_decode_relocation_bench.sv]
// self-checking bench for the internal i/o window decoder
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module internal_io_decode_relocation_bench;
	import iwd_pkg::*;
	logic             ref_clk, rst, ioReq, ioWrite, stall, lastHit, prevWr, prevRd;
	logic      [15:0] ioAddr, extAddr, addrSeen;
	iwd_byte_t        ioWrData, ioRdData, extRdData, extWrData, wrSeen, r, d;
	logic             ioAck, ioInternal, extIorq, extRd, extWr, extWait;
	logic      [1:0]  window_base_field, base;
	logic             peripheral_halt_mode;
	iwd_byte_t        shadow [64];
	logic             valid [64];
	int               failures, num_checks, n, wrCnt, rdCnt;
	logic      [5:0]  off;

	iwd_top i_dut (.ref_clk(ref_clk), .rst(rst), .ioReq(ioReq), .ioWrite(ioWrite),
		.ioAddr(ioAddr), .ioWrData(ioWrData), .ioAck(ioAck), .ioInternal(ioInternal),
		.ioRdData(ioRdData), .extWait(extWait), .extRdData(extRdData), .extIorq(extIorq),
		.extRd(extRd), .extWr(extWr), .extAddr(extAddr), .extWrData(extWrData),
		.window_base_field(window_base_field), .peripheral_halt_mode(peripheral_halt_mode));
	iwd_ext_dev i_ext (.ref_clk(ref_clk), .rst(rst), .extIorq(extIorq), .extRd(extRd),
		.extAddr(extAddr), .stall(stall), .extWait(extWait), .extRdData(extRdData));

	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// count strobe rises and keep what the bus carried on a write
	always @(posedge ref_clk)
	begin
		if (extWr === 1'b1 && prevWr !== 1'b1)
		begin
			wrCnt++;
			wrSeen = extWrData;
			addrSeen = extAddr;
		end
		if (extRd === 1'b1 && prevRd !== 1'b1)
			rdCnt++;
		prevWr = extWr;
		prevRd = extRd;
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// one cpu i/o cycle; n counts edges from request to acknowledge
	task automatic acc(input logic w, input logic [15:0] a, input iwd_byte_t wd);
		@(posedge ref_clk);
		ioReq <= 1'b1;
		ioWrite <= w;
		ioAddr <= a;
		ioWrData <= wd;
		n = 0;
		wrCnt = 0;
		rdCnt = 0;
		while (n < 40)
		begin
			@(posedge ref_clk);
			n++;
			if (n == 1)
				lastHit = ioInternal;
			if (ioAck === 1'b1)
				break;
		end
		`CHK(ioAck, 1'b1)
		r = ioRdData;
		ioReq <= 1'b0;
	endtask

	// internal access at the current base with the mirror checks
	task automatic int_acc(input logic w, input logic [5:0] o, input iwd_byte_t wd);
		acc(w, {8'h00, base, o}, wd);
		`CHK(lastHit, 1'b1)
		`CHK(n, 6)
		`CHK(w ? wrCnt : rdCnt, 1)
		if (w)
		begin
			`CHK(wrSeen, wd)
			`CHK(addrSeen, {8'h00, base, o})
		end
	endtask

	initial
	begin
		#100000;
		failures++;
		close_out();
	end

	initial
	begin
		rst = 1'b1;
		ioReq = 1'b0;
		ioWrite = 1'b0;
		ioAddr = 16'h0000;
		ioWrData = 8'h00;
		stall = 1'b0;
		base = 2'b00;
		foreach (valid[i]) valid[i] = 1'b0;
		void'($urandom(32'hf8de));
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		#1;
		`CHK(window_base_field, 2'b00)
		`CHK(peripheral_halt_mode, 1'b0)
		int_acc(1'b0, 6'h3f, 8'h00);
		`CHK(r, 8'h00)
		$display("test reset done");
		for (int i = 0; i < 48; i++)
		begin
			off = 6'($urandom_range(0, 62));
			d = 8'($urandom);
			stall <= 1'($urandom);
			if (!valid[off] || $urandom_range(0, 1))
			begin
				int_acc(1'b1, off, d);
				shadow[off] = d;
				valid[off] = 1'b1;
			end
			else
			begin
				int_acc(1'b0, off, d);
				`CHK(r, shadow[off])
			end
		end
		$display("test storage done");
		for (int b = 1; b <= 4; b++)
		begin
			d = {2'(b), 1'(b), 5'h1f};
			int_acc(1'b1, 6'h3f, d);
			base = 2'(b);
			`CHK(window_base_field, base)
			`CHK(peripheral_halt_mode, 1'(b))
			int_acc(1'b0, 6'h3f, 8'h00);
			`CHK(r, {base, 1'(b), 5'h00})
			acc(1'b0, {8'h00, base ^ 2'b10, 6'h3f}, 8'h00);
			`CHK(lastHit, 1'b0)
			`CHK(r, {base ^ 2'b10, 6'h3f} ^ 8'h5a)
			acc(1'b0, {8'h01, base, 6'h3f}, 8'h00);
			`CHK(lastHit, 1'b0)
			off = 6'($urandom_range(0, 62));
			if (valid[off])
			begin
				int_acc(1'b0, off, 8'h00);
				`CHK(r, shadow[off])
			end
		end
		$display("test relocation done");
		// external device placed above the internal range
		stall <= 1'b0;
		acc(1'b0, 16'h0140, 8'h00);
		`CHK(n, 5)
		`CHK(r, 8'h40 ^ 8'h5a)
		stall <= 1'b1;
		acc(1'b1, 16'h0240, 8'h3c);
		`CHK(n > 5, 1'b1)
		`CHK(wrSeen, 8'h3c)
		`CHK(addrSeen, 16'h0240)
		int_acc(1'b1, 6'h00, 8'ha5);
		$display("test external done");
		close_out();
	end
endmodule
